// ### include/video_dac_pkg.sv
// Shared constants and carriers for the video DAC control register block
package video_dac_pkg;
  localparam int DATA_W = 10;
  localparam logic [7:0] IDX_PIXEL_CONTROL_TEST = 8'h02;
  localparam logic [7:0] IDX_IDENTIFICATION = 8'h03;
  localparam logic [7:0] IDX_PIXEL_MASK = 8'h04;
  localparam logic [7:0] IDX_COMMAND_ONE = 8'h05;
  localparam logic [7:0] IDX_COMMAND_TWO = 8'h06;
  localparam logic [7:0] IDX_COMMAND_THREE = 8'h07;
  localparam logic [7:0] IDX_SILICON_REVISION = 8'h0B;
  localparam logic [1:0] CTRL_INDEX = 2'h0;
  localparam logic [1:0] CTRL_REGISTER = 2'h2;
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic [2:0] RST_PIXEL_CONTROL_TEST = 3'h0;
  localparam logic [7:0] RST_PIXEL_MASK = 8'hFF;
  localparam logic [7:0] RST_COMMAND_ONE = 8'h00;
  localparam logic [7:0] RST_COMMAND_TWO = 8'hFF;
  localparam logic [7:0] RST_COMMAND_THREE = 8'hFF;
  localparam logic [7:0] CMD1_STORED_MASK = 8'h05;
  localparam int CMD1_CALIBRATE_BIT = 0;
  localparam int CMD1_SYNC_OUT_BIT = 2;
  localparam int CMD2_CAPTURE_EDGE_BIT = 0;
  localparam int CMD2_PHASE_REF_SEL_BIT = 1;
  localparam int CMD2_SYNC_ON_GREEN_BIT = 2;
  localparam int CMD2_PEDESTAL_BIT = 3;
  localparam int CMD2_COLOR_MODE_LSB = 4;
  localparam int CMD3_RATIO_LSB = 0;
  localparam int CMD3_BLANK_DELAY_LSB = 2;
  localparam int CMD3_MULTIPLEX_LSB = 6;
  localparam int TEST_SYNC_BIT = 0;
  localparam int TEST_BLANK_BIT = 1;
  localparam int TEST_PHASE_BIT = 2;
  localparam logic [2:0] PRG_CLOCK_BASE_EXP = 3'h2;
  localparam logic [2:0] LOAD_EXP_ONE = 3'h0;
  localparam logic [2:0] LOAD_EXP_TWO = 3'h1;
  localparam logic [2:0] LOAD_EXP_FOUR = 3'h2;
  localparam int COUNT_W = 5;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pixel_s;

  typedef struct packed {
    logic [9:0] red_true;
    logic [9:0] red_comp;
    logic [9:0] green_true;
    logic [9:0] green_comp;
    logic [9:0] blue_true;
    logic [9:0] blue_comp;
    logic pedestal_on;
    logic green_sync_offset_on;
  } dac_out_s;
endpackage

// ### verilog/clock_ratio_divider.sv
// Power-of-two divider giving a strobe pulse and a square clock
`timescale 1ns/10ps
module clock_ratio_divider
#(
  parameter int COUNT_W = video_dac_pkg::COUNT_W
)
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [2:0] exponent_i,
  output logic pulse_o,
  output logic square_o
);
  import video_dac_pkg::*;

  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] mask;
  logic pulse_reg;
  logic square_reg;

  generate
    if (COUNT_W < 5)
    begin : g_check
      $error("counter too narrow for divide by 32");
    end
  endgenerate

  assign mask = ~({COUNT_W{1'b1}} << exponent_i);

  // Free running so a ratio change takes effect without a restart
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      count_reg <= '0;
    else
      count_reg <= count_reg + 1'b1;
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pulse_reg <= 1'b0;
      square_reg <= 1'b0;
    end
    else
    begin
      pulse_reg <= ((count_reg & mask) == mask);
      if (exponent_i == 3'h0)
        square_reg <= ~square_reg;
      else
        square_reg <= count_reg[exponent_i - 3'h1];
    end
  end

  assign pulse_o = pulse_reg;
  assign square_o = square_reg;
endmodule

// ### verilog/video_level_encoder.sv
// Per-channel DAC code and level flags from pixel, blank and sync
`timescale 1ns/10ps
module video_level_encoder
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire video_dac_pkg::pixel_s pixel_i,
  input wire logic blank_active_i,
  input wire logic sync_active_i,
  input wire logic sync_on_green_i,
  input wire logic pedestal_i,
  output video_dac_pkg::dac_out_s dac_o
);
  import video_dac_pkg::*;

  dac_out_s dac_reg;

  // Blank forces code zero; pixel fills the upper eight bits
  function automatic logic [9:0] level(input logic [7:0] value, input logic blank);
    level = blank ? 10'h000 : {value, 2'h0};
  endfunction

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      // Code zero in reset, so all current on the complement
      dac_reg <= '{red_comp: 10'h3FF, green_comp: 10'h3FF, blue_comp: 10'h3FF, default: '0};
    else
    begin
      dac_reg.red_true <= level(pixel_i.red, blank_active_i);
      dac_reg.red_comp <= ~level(pixel_i.red, blank_active_i);
      dac_reg.green_true <= level(pixel_i.green, blank_active_i);
      dac_reg.green_comp <= ~level(pixel_i.green, blank_active_i);
      dac_reg.blue_true <= level(pixel_i.blue, blank_active_i);
      dac_reg.blue_comp <= ~level(pixel_i.blue, blank_active_i);
      dac_reg.pedestal_on <= pedestal_i & ~blank_active_i;
      // Green offset drops only with sync, giving sync level under blank
      dac_reg.green_sync_offset_on <= sync_on_green_i & ~sync_active_i;
    end
  end

  assign dac_o = dac_reg;
endmodule

// ### verilog/video_dac_control_registers.sv
// Indexed control registers and pixel control path of the video DAC
// Notes on behaviour
// - Index 02H: 3-bit read/write test register
// - Index 03H: fixed read-only identification code
// - Mask ANDs every red, green, blue pixel
// - Mask bit n covers bit n everywhere
// - Command-one reads zero in bits 1, 3-9
// - Bit 0 calibrates; mode calibrate bit low
// - Sync output enable bit, resets to off
// - Command-two read/write, bits 8-9 read zero
// - Capture on chosen edge of red MSB
// - Phase reference from blank or sync fall
// - Sync encoded on green or ignored
// - Pedestal zero or 7.5 IRE
// - Command-two upper nibble picks color mode
// - Command-three read/write, bits 8-9 read zero
// - Bits 1-0 set divided clock ratio
// - Bits 5-2 add extra blank delay
// - Bits 7-6 multiplex mode, load strobe rate
// - Index 0BH: read-only silicon revision
// - One steers current true, zero complementary
// - Blank ignores pixel; sync drops further
// - Reset: command-one zeros, two and three ones
`timescale 1ns/10ps
module video_dac_control_registers
#(
  parameter logic [7:0] ID_CODE = 8'h5A,
  parameter logic [7:0] REVISION_CODE = 8'h01,
  parameter int DELAY_STAGES = 16
)
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic mpu_write_n_i,
  input wire logic mpu_read_n_i,
  input wire logic [1:0] mpu_ctrl_i,
  input wire logic [video_dac_pkg::DATA_W-1:0] mpu_data_i,
  output logic [video_dac_pkg::DATA_W-1:0] mpu_data_o,
  output logic mpu_data_oe_o,
  input wire logic diag_mode_i,
  input wire logic mode_calibrate_bit_i,
  input wire video_dac_pkg::pixel_s pixel_i,
  input wire logic blank_n_i,
  input wire logic sync_n_i,
  output logic calibrate_start_o,
  output logic composite_sync_out_pin_o,
  output logic composite_sync_out_pin_oe_o,
  output logic phase_reference_out_o,
  output logic programmable_divided_clock_o,
  output logic load_strobe_out_o,
  output logic [3:0] color_mode_field_o,
  output logic [1:0] pixel_multiplex_field_o,
  output video_dac_pkg::dac_out_s dac_o
);
  import video_dac_pkg::*;

  // ID_CODE and REVISION_CODE defaults are arbitrary values
  generate
    if (DELAY_STAGES < 16)
    begin : g_check
      $error("blank delay needs sixteen stages");
    end
  endgenerate

  logic [2:0] wr_sync_reg;
  logic [2:0] rd_sync_reg;
  logic wr_level_reg;
  logic rd_level_reg;
  logic [DATA_W-1:0] data_d1_reg;
  logic [DATA_W-1:0] data_d2_reg;
  logic [1:0] ctrl_d1_reg;
  logic [1:0] ctrl_d2_reg;
  logic write_event;
  logic reg_write;
  logic [7:0] index_register_reg;
  logic [2:0] pixel_control_test_reg;
  logic [7:0] pixel_mask_reg;
  logic [7:0] command_one_reg;
  logic [7:0] command_two_reg;
  logic [7:0] command_three_reg;
  logic [DATA_W-1:0] mpu_data_reg;
  logic mpu_data_oe_reg;
  logic calibrate_start_reg;
  pixel_s masked_pixel_reg;
  logic [DELAY_STAGES-1:0] blank_pipe_reg;
  logic sync_active_reg;
  logic blank_n_prev_reg;
  logic sync_n_prev_reg;
  logic red_msb_prev_reg;
  logic phase_reference_reg;
  logic sync_out_reg;
  logic sync_out_oe_reg;
  logic capture_edge;
  logic [2:0] load_exponent;
  logic [2:0] prg_exponent;

  // Strobes are asynchronous pins: three flops, change once two agree
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_sync_reg <= 3'h7;
      rd_sync_reg <= 3'h7;
      wr_level_reg <= 1'b1;
      rd_level_reg <= 1'b1;
    end
    else
    begin
      wr_sync_reg <= {wr_sync_reg[1:0], mpu_write_n_i};
      rd_sync_reg <= {rd_sync_reg[1:0], mpu_read_n_i};
      if (wr_sync_reg[1] == wr_sync_reg[2])
        wr_level_reg <= wr_sync_reg[2];
      if (rd_sync_reg[1] == rd_sync_reg[2])
        rd_level_reg <= rd_sync_reg[2];
    end
  end

  // Bus held stable around the strobe, so two stages suffice here
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      data_d1_reg <= '0;
      data_d2_reg <= '0;
      ctrl_d1_reg <= 2'h0;
      ctrl_d2_reg <= 2'h0;
    end
    else
    begin
      data_d1_reg <= mpu_data_i;
      data_d2_reg <= data_d1_reg;
      ctrl_d1_reg <= mpu_ctrl_i;
      ctrl_d2_reg <= ctrl_d1_reg;
    end
  end

  // Write taken on the end of the strobe
  assign write_event = (wr_sync_reg[1] == wr_sync_reg[2]) && wr_sync_reg[2] && !wr_level_reg;
  assign reg_write = write_event && (ctrl_d2_reg == CTRL_REGISTER);

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      index_register_reg <= RST_INDEX;
    else if (write_event && ctrl_d2_reg == CTRL_INDEX)
      index_register_reg <= data_d2_reg[7:0];
  end

  // Read-only and unmapped indices match none of these arms
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pixel_mask_reg <= RST_PIXEL_MASK;
      command_one_reg <= RST_COMMAND_ONE;
      command_two_reg <= RST_COMMAND_TWO;
      command_three_reg <= RST_COMMAND_THREE;
    end
    else if (reg_write)
    begin
      case (index_register_reg)
        IDX_PIXEL_MASK: pixel_mask_reg <= data_d2_reg[7:0];
        IDX_COMMAND_ONE: command_one_reg <= data_d2_reg[7:0] & CMD1_STORED_MASK;
        IDX_COMMAND_TWO: command_two_reg <= data_d2_reg[7:0];
        IDX_COMMAND_THREE: command_three_reg <= data_d2_reg[7:0];
        default: ;
      endcase
    end
  end

  // Calibration launches on a 0 to 1 write, only with mode bit clear
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      calibrate_start_reg <= 1'b0;
    else
      calibrate_start_reg <= reg_write && index_register_reg == IDX_COMMAND_ONE
        && data_d2_reg[CMD1_CALIBRATE_BIT] && !command_one_reg[CMD1_CALIBRATE_BIT]
        && !mode_calibrate_bit_i;
  end

  function automatic logic [DATA_W-1:0] read_value(input logic [7:0] idx);
    case (idx)
      IDX_PIXEL_CONTROL_TEST: read_value = {7'h00, pixel_control_test_reg};
      IDX_IDENTIFICATION: read_value = {2'h0, ID_CODE};
      IDX_PIXEL_MASK: read_value = {2'h0, pixel_mask_reg};
      IDX_COMMAND_ONE: read_value = {2'h0, command_one_reg & CMD1_STORED_MASK};
      IDX_COMMAND_TWO: read_value = {2'h0, command_two_reg};
      IDX_COMMAND_THREE: read_value = {2'h0, command_three_reg};
      IDX_SILICON_REVISION: read_value = {2'h0, REVISION_CODE};
      default: read_value = '0;
    endcase
  endfunction

  // Drive the bus while the read strobe stands low
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mpu_data_reg <= '0;
      mpu_data_oe_reg <= 1'b0;
    end
    else if (!rd_level_reg)
    begin
      mpu_data_oe_reg <= 1'b1;
      if (ctrl_d2_reg == CTRL_INDEX)
        mpu_data_reg <= {2'h0, index_register_reg};
      else if (ctrl_d2_reg == CTRL_REGISTER)
        mpu_data_reg <= read_value(index_register_reg);
      else
        mpu_data_reg <= '0;
    end
    else
    begin
      mpu_data_reg <= '0;
      mpu_data_oe_reg <= 1'b0;
    end
  end

  // Pixel pins are on the pixel clock, so no synchroniser
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      masked_pixel_reg <= '0;
      sync_active_reg <= 1'b0;
    end
    else
    begin
      masked_pixel_reg.red <= pixel_i.red & pixel_mask_reg;
      masked_pixel_reg.green <= pixel_i.green & pixel_mask_reg;
      masked_pixel_reg.blue <= pixel_i.blue & pixel_mask_reg;
      sync_active_reg <= ~sync_n_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      blank_pipe_reg[0] <= 1'b0;
    else
      blank_pipe_reg[0] <= ~blank_n_i;
  end

  genvar g;
  generate
    for (g = 1; g < DELAY_STAGES; g++)
    begin : g_blank_pipe
      always_ff @(posedge clock_i or negedge nrst_i)
      begin
        if (!nrst_i)
          blank_pipe_reg[g] <= 1'b0;
        else
          blank_pipe_reg[g] <= blank_pipe_reg[g-1];
      end
    end
  endgenerate

  // Edge detection of blank, sync and red MSB
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      blank_n_prev_reg <= 1'b1;
      sync_n_prev_reg <= 1'b1;
      red_msb_prev_reg <= 1'b0;
      phase_reference_reg <= 1'b0;
    end
    else
    begin
      blank_n_prev_reg <= blank_n_i;
      sync_n_prev_reg <= sync_n_i;
      red_msb_prev_reg <= pixel_i.red[7];
      if (command_two_reg[CMD2_PHASE_REF_SEL_BIT])
        phase_reference_reg <= sync_n_prev_reg && !sync_n_i;
      else
        phase_reference_reg <= blank_n_prev_reg && !blank_n_i;
    end
  end

  // Zero captures on rising, one on falling edge of red MSB
  assign capture_edge = command_two_reg[CMD2_CAPTURE_EDGE_BIT]
    ? (red_msb_prev_reg && !pixel_i.red[7])
    : (!red_msb_prev_reg && pixel_i.red[7]);

  // A diagnostic capture beats a host write in the same cycle
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pixel_control_test_reg <= RST_PIXEL_CONTROL_TEST;
    else if (diag_mode_i && capture_edge)
    begin
      pixel_control_test_reg[TEST_SYNC_BIT] <= sync_active_reg;
      pixel_control_test_reg[TEST_BLANK_BIT] <= blank_pipe_reg[0];
      pixel_control_test_reg[TEST_PHASE_BIT] <= phase_reference_reg;
    end
    else if (reg_write && index_register_reg == IDX_PIXEL_CONTROL_TEST)
      pixel_control_test_reg <= data_d2_reg[2:0];
  end

  // Composite sync pin, active low, released while disabled
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync_out_reg <= 1'b1;
      sync_out_oe_reg <= 1'b0;
    end
    else
    begin
      sync_out_reg <= ~sync_active_reg;
      sync_out_oe_reg <= command_one_reg[CMD1_SYNC_OUT_BIT];
    end
  end

  // Divide by 4, 8, 16, 32; reset ones give 32
  assign prg_exponent = PRG_CLOCK_BASE_EXP
    + {1'b0, command_three_reg[CMD3_RATIO_LSB +: 2]};

  // 1:1, 2:1, 4:1; the spare code also runs 4:1
  always_comb
  begin
    unique case (command_three_reg[CMD3_MULTIPLEX_LSB +: 2])
      2'h0: load_exponent = LOAD_EXP_ONE;
      2'h1: load_exponent = LOAD_EXP_TWO;
      2'h2: load_exponent = LOAD_EXP_FOUR;
      2'h3: load_exponent = LOAD_EXP_FOUR;
    endcase
  end

  clock_ratio_divider u_prg_divider
  (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .exponent_i(prg_exponent),
    .pulse_o(),
    .square_o(programmable_divided_clock_o)
  );

  clock_ratio_divider u_load_divider
  (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .exponent_i(load_exponent),
    .pulse_o(load_strobe_out_o),
    .square_o()
  );

  video_level_encoder u_encoder
  (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .pixel_i(masked_pixel_reg),
    .blank_active_i(blank_pipe_reg[command_three_reg[CMD3_BLANK_DELAY_LSB +: 4]]),
    .sync_active_i(sync_active_reg),
    .sync_on_green_i(command_two_reg[CMD2_SYNC_ON_GREEN_BIT]),
    .pedestal_i(command_two_reg[CMD2_PEDESTAL_BIT]),
    .dac_o(dac_o)
  );

  assign mpu_data_o = mpu_data_reg;
  assign mpu_data_oe_o = mpu_data_oe_reg;
  assign calibrate_start_o = calibrate_start_reg;
  assign composite_sync_out_pin_o = sync_out_reg;
  assign composite_sync_out_pin_oe_o = sync_out_oe_reg;
  assign phase_reference_out_o = phase_reference_reg;
  assign color_mode_field_o = command_two_reg[CMD2_COLOR_MODE_LSB +: 4];
  assign pixel_multiplex_field_o = command_three_reg[CMD3_MULTIPLEX_LSB +: 2];

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  sequence index_then_write(logic [7:0] idx);
    write_event && ctrl_d2_reg == CTRL_INDEX && data_d2_reg[7:0] == idx
    ##[1:300] (reg_write && index_register_reg == idx);
  endsequence

  mask_write_seq_a: assert property (
    index_then_write(IDX_PIXEL_MASK) |=> pixel_mask_reg == $past(data_d2_reg[7:0]))
    else $error("mask not written after index then data");

  pixel_mask_and_a: assert property (
    ##1 masked_pixel_reg == {$past(pixel_i.red) & $past(pixel_mask_reg),
      $past(pixel_i.green) & $past(pixel_mask_reg),
      $past(pixel_i.blue) & $past(pixel_mask_reg)})
    else $error("pixel not masked bitwise");

  id_read_fixed_a: assert property (
    !rd_level_reg && ctrl_d2_reg == CTRL_REGISTER && index_register_reg == IDX_IDENTIFICATION
    |=> mpu_data_o == {2'h0, ID_CODE} && mpu_data_oe_o)
    else $error("identification read wrong");

  cmd_one_zero_a: assert property (
    !rd_level_reg && ctrl_d2_reg == CTRL_REGISTER && index_register_reg == IDX_COMMAND_ONE
    |=> (mpu_data_o & 10'h3FA) == 10'h000)
    else $error("command one reserved bits not zero");

  cmd_reserved_zero_a: assert property (
    !rd_level_reg && ctrl_d2_reg == CTRL_REGISTER
    && (index_register_reg == IDX_COMMAND_TWO || index_register_reg == IDX_COMMAND_THREE)
    |=> mpu_data_o[9:8] == 2'h0)
    else $error("command two or three bits 8-9 not zero");

  calibrate_gate_a: assert property (
    calibrate_start_o |-> $past(!mode_calibrate_bit_i) && command_one_reg[CMD1_CALIBRATE_BIT])
    else $error("calibration started with mode bit set");

  sync_out_enable_a: assert property (
    composite_sync_out_pin_oe_o == $past(command_one_reg[CMD1_SYNC_OUT_BIT]))
    else $error("sync output enable does not follow bit 2");

  phase_ref_source_a: assert property (
    command_two_reg[CMD2_PHASE_REF_SEL_BIT] && $fell(sync_n_i) && $stable(command_two_reg)
    |=> phase_reference_out_o)
    else $error("phase reference missed sync fall");

  blank_level_out_a: assert property (
    command_three_reg[5:2] == 4'h0 && blank_pipe_reg[0]
    |=> dac_o.red_true == 10'h000 && dac_o.green_true == 10'h000)
    else $error("pixel data passed during blank");

  current_steer_a: assert property (
    dac_o.red_comp == ~dac_o.red_true && dac_o.blue_comp == ~dac_o.blue_true)
    else $error("complementary outputs not inverted");

  ignore_ro_write_a: assert property (
    reg_write && index_register_reg == IDX_IDENTIFICATION
    |=> $stable(pixel_mask_reg) && $stable(command_two_reg) && $stable(command_three_reg))
    else $error("read-only write changed state");
endmodule

// ### verif/mpu_host_model.sv
// Host processor model on the indexed register port
`timescale 1ns/10ps
module mpu_host_model
(
  input wire logic clock_i,
  input wire logic [9:0] rd_data_i,
  input wire logic rd_oe_i,
  output logic write_n_o,
  output logic read_n_o,
  output logic [1:0] ctrl_o,
  output logic [9:0] data_o
);
  initial
  begin
    write_n_o = 1'b1;
    read_n_o = 1'b1;
    ctrl_o = 2'h1;
    data_o = 10'h000;
  end
  // Strobe low 4 cycles, data held 4 more, then bus scrambled
  task automatic wr(input logic [1:0] c, input logic [9:0] d);
    @(negedge clock_i);
    ctrl_o = c;
    data_o = d;
    write_n_o = 1'b0;
    repeat (4) @(negedge clock_i);
    write_n_o = 1'b1;
    repeat (4) @(negedge clock_i);
    data_o = ~d;
    ctrl_o = 2'h1;
    repeat (3) @(negedge clock_i);
  endtask
  // Read data taken at the edge where enable is seen
  task automatic rd(output logic [9:0] q);
    int n = 0;
    @(negedge clock_i);
    ctrl_o = 2'h2;
    read_n_o = 1'b0;
    do
    begin
      @(posedge clock_i);
      n++;
    end while (rd_oe_i !== 1'b1 && n < 12);
    q = (rd_oe_i === 1'b1) ? rd_data_i : 'x;
    @(negedge clock_i);
    read_n_o = 1'b1;
    ctrl_o = 2'h1;
    repeat (7) @(negedge clock_i);
  endtask
endmodule

// ### verif/video_dac_control_registers_tb.sv
// Self-checking bench for the video DAC control registers
`timescale 1ns/10ps
module video_dac_control_registers_tb;
  import video_dac_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary code
  localparam logic [7:0] REV_VAL = 8'h07; // Arbitrary code
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wn;
  logic rn;
  logic [1:0] ctrl;
  logic [9:0] din;
  logic [9:0] dout;
  logic oe;
  logic diag = 1'b0;
  logic mcal = 1'b0;
  pixel_s pix = '0;
  logic blank_n = 1'b1;
  logic sync_n = 1'b1;
  logic cal;
  logic spin;
  logic spin_oe;
  logic pref;
  logic prg;
  logic lds;
  logic [3:0] cmode;
  logic [1:0] pmux;
  dac_out_s dac;
  int err_count = 0;
  int compares = 0;
  int cal_cnt = 0;
  int pref_cnt = 0;
  int prg_cnt = 0;
  int lds_cnt = 0;
  logic prg_q = 1'b0;
  always #2 clock_i = ~clock_i;
  mpu_host_model u_mpu_host_model
  (
    .clock_i(clock_i),
    .rd_data_i(dout),
    .rd_oe_i(oe),
    .write_n_o(wn),
    .read_n_o(rn),
    .ctrl_o(ctrl),
    .data_o(din)
  );
  video_dac_control_registers
  #(
    .ID_CODE(ID_VAL),
    .REVISION_CODE(REV_VAL)
  )
  u_video_dac_control_registers
  (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .mpu_write_n_i(wn),
    .mpu_read_n_i(rn),
    .mpu_ctrl_i(ctrl),
    .mpu_data_i(din),
    .mpu_data_o(dout),
    .mpu_data_oe_o(oe),
    .diag_mode_i(diag),
    .mode_calibrate_bit_i(mcal),
    .pixel_i(pix),
    .blank_n_i(blank_n),
    .sync_n_i(sync_n),
    .calibrate_start_o(cal),
    .composite_sync_out_pin_o(spin),
    .composite_sync_out_pin_oe_o(spin_oe),
    .phase_reference_out_o(pref),
    .programmable_divided_clock_o(prg),
    .load_strobe_out_o(lds),
    .color_mode_field_o(cmode),
    .pixel_multiplex_field_o(pmux),
    .dac_o(dac)
  );
  // Pulse and edge counters, read as differences by the tests
  always @(posedge clock_i)
  begin
    prg_q <= prg;
    cal_cnt <= cal_cnt + int'(cal === 1'b1);
    pref_cnt <= pref_cnt + int'(pref === 1'b1);
    lds_cnt <= lds_cnt + int'(lds === 1'b1);
    prg_cnt <= prg_cnt + int'(prg === 1'b1 && prg_q === 1'b0);
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [9:0] v);
    u_mpu_host_model.wr(CTRL_INDEX, {2'h0, idx});
    u_mpu_host_model.wr(CTRL_REGISTER, v);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [9:0] e);
    logic [9:0] q;
    u_mpu_host_model.wr(CTRL_INDEX, {2'h0, idx});
    u_mpu_host_model.rd(q);
    chk(q, e);
  endtask
  task automatic end_sim;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Whole run needs about 9 us
  initial
  begin
    #200000;
    err_count++;
    end_sim();
  end
  initial
  begin
    int a;
    cyc(20);
    nrst_i = 1'b1;
    rchk(IDX_COMMAND_ONE, 10'h000);
    rchk(IDX_COMMAND_TWO, 10'h0FF);
    rchk(IDX_COMMAND_THREE, 10'h0FF);
    rchk(IDX_PIXEL_CONTROL_TEST, 10'h000);
    rchk(IDX_IDENTIFICATION, {2'h0, ID_VAL});
    rchk(IDX_SILICON_REVISION, {2'h0, REV_VAL});
    chk(10'(spin_oe), 10'h000);
    $display("reset test done");
    // Reserved bits written high where the host may
    wreg(IDX_PIXEL_CONTROL_TEST, 10'h3FF);
    rchk(IDX_PIXEL_CONTROL_TEST, 10'h007);
    wreg(IDX_COMMAND_ONE, 10'h300);
    rchk(IDX_COMMAND_ONE, 10'h000);
    wreg(IDX_COMMAND_TWO, 10'h3FF);
    rchk(IDX_COMMAND_TWO, 10'h0FF);
    wreg(IDX_COMMAND_TWO, 10'h15C);
    rchk(IDX_COMMAND_TWO, 10'h05C);
    chk(10'(cmode), 10'h005);
    wreg(IDX_COMMAND_THREE, 10'h3FF);
    rchk(IDX_COMMAND_THREE, 10'h0FF);
    wreg(IDX_COMMAND_THREE, 10'h200);
    rchk(IDX_COMMAND_THREE, 10'h000);
    wreg(IDX_IDENTIFICATION, 10'h000);
    rchk(IDX_IDENTIFICATION, {2'h0, ID_VAL});
    wreg(IDX_SILICON_REVISION, 10'h0FE);
    rchk(IDX_SILICON_REVISION, {2'h0, REV_VAL});
    wreg(8'h09, 10'h000);
    rchk(8'h09, 10'h000);
    rchk(IDX_COMMAND_TWO, 10'h05C);
    $display("register test done");
    a = cal_cnt;
    wreg(IDX_COMMAND_ONE, 10'h005);
    chk(10'(cal_cnt - a), 10'h001);
    chk(10'(spin_oe), 10'h001);
    wreg(IDX_COMMAND_ONE, 10'h004);
    mcal = 1'b1;
    wreg(IDX_COMMAND_ONE, 10'h005);
    chk(10'(cal_cnt - a), 10'h001);
    sync_n = 1'b0;
    cyc(3);
    chk(10'(spin), 10'h000);
    sync_n = 1'b1;
    cyc(3);
    chk(10'(spin), 10'h001);
    $display("command one test done");
    wreg(IDX_PIXEL_MASK, 10'h00F);
    pix = {8'hF0, 8'h3F, 8'h0F};
    cyc(6);
    chk(dac.red_true, 10'h000);
    chk(dac.red_comp, 10'h3FF);
    chk(dac.green_true, 10'h03C);
    chk(dac.blue_true, 10'h03C);
    chk(dac.blue_comp, 10'h3C3);
    chk(10'(dac.pedestal_on), 10'h001);
    chk(10'(dac.green_sync_offset_on), 10'h001);
    a = pref_cnt;
    sync_n = 1'b0;
    cyc(6);
    chk(10'(dac.green_sync_offset_on), 10'h000);
    blank_n = 1'b0;
    cyc(6);
    chk(dac.green_true | dac.blue_true, 10'h000);
    chk(10'(dac.pedestal_on), 10'h000);
    chk(10'(pref_cnt - a), 10'h001);
    blank_n = 1'b1;
    sync_n = 1'b1;
    wreg(IDX_COMMAND_TWO, 10'h05E);
    a = pref_cnt;
    blank_n = 1'b0;
    cyc(4);
    sync_n = 1'b0;
    cyc(4);
    chk(10'(pref_cnt - a), 10'h001);
    blank_n = 1'b1;
    wreg(IDX_PIXEL_MASK, 10'h0FF);
    rchk(IDX_PIXEL_MASK, 10'h0FF);
    $display("video test done");
    // Sync held active, so captured bit 0 reads one
    diag = 1'b1;
    pix.red = 8'h00;
    wreg(IDX_COMMAND_TWO, 10'h05C);
    wreg(IDX_PIXEL_CONTROL_TEST, 10'h000);
    pix.red = 8'h80;
    cyc(3);
    rchk(IDX_PIXEL_CONTROL_TEST, 10'h001);
    pix.red = 8'h00;
    wreg(IDX_COMMAND_TWO, 10'h05D);
    wreg(IDX_PIXEL_CONTROL_TEST, 10'h000);
    pix.red = 8'h80;
    cyc(3);
    rchk(IDX_PIXEL_CONTROL_TEST, 10'h000);
    pix.red = 8'h00;
    cyc(3);
    rchk(IDX_PIXEL_CONTROL_TEST, 10'h001);
    diag = 1'b0;
    $display("capture test done");
    for (int r = 0; r < 4; r++)
    begin
      wreg(IDX_COMMAND_THREE, {2'h0, 2'(r), 4'h0, 2'(r)});
      chk(10'(pmux), 10'(r));
      a = prg_cnt;
      cyc(128);
      chk(10'(prg_cnt - a), 10'(128 >> (2 + r)));
      a = lds_cnt;
      cyc(128);
      chk(10'(lds_cnt - a), 10'(128 >> ((r > 2) ? 2 : r)));
    end
    $display("divider test done");
    // Blank held back three extra cycles
    wreg(IDX_COMMAND_THREE, 10'h00C);
    blank_n = 1'b0;
    cyc(4);
    chk(dac.green_true, 10'h0FC);
    cyc(2);
    chk(dac.green_true, 10'h000);
    blank_n = 1'b1;
    $display("delay test done");
    end_sim();
  end
endmodule
